// file: icp_pkg.sv
// Constants, register map and types of the inductive channel processing block.
package icp_pkg;

  // ==========================================================================
  // Data widths and limits
  localparam int          CW          = 11;
  localparam int          NCH         = 4;
  localparam int          FRAC        = 8;
  localparam logic [11:0] SAT_LIMIT   = 12'h07ff;
  localparam logic [3:0]  RF_BLANK    = 4'h4;
  localparam logic [1:0]  AVG_DIV3    = 2'h2;

  // ==========================================================================
  // Register word indices (byte address is four times the index)
  localparam logic [3:0] IDX_CTRL   = 4'h0;
  localparam logic [3:0] IDX_STAT   = 4'h1;
  localparam logic [3:0] IDX_EVENTS = 4'h2;
  localparam logic [3:0] IDX_GLOBAL = 4'h3;
  localparam logic [3:0] IDX_BETA   = 4'h4;
  localparam logic [3:0] IDX_FILT   = 4'h5;
  localparam logic [3:0] IDX_HALT   = 4'h6;
  localparam logic [3:0] IDX_UI     = 4'h7;
  localparam logic [3:0] IDX_TRIG   = 4'h8;
  localparam logic [3:0] IDX_LEVEL  = 4'h9;
  localparam logic [3:0] IDX_COUNT0 = 4'ha;

  // ==========================================================================
  // Field positions
  localparam int CTRL_RESEED = 0;
  localparam int CTRL_LOWPWR = 1;
  localparam int CTRL_TUNE   = 2;
  localparam int STAT_TERR   = 0;
  localparam int STAT_TBUSY  = 1;
  localparam int STAT_ACT    = 4;
  localparam int EVT_ACT     = 4;
  localparam int GLB_AVG     = 0;
  localparam int GLB_BAND    = 2;
  localparam int GLB_TARGET  = 16;
  localparam int FLT_HALT    = 0;
  localparam int FLT_FAST    = 16;
  localparam int HLT_TIMEOUT = 0;
  localparam int HLT_RF      = 16;
  localparam int UI_MAXD     = 0;
  localparam int UI_NTHR     = 12;
  localparam int UI_HYST     = 16;
  localparam int CNT_REF     = 16;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] GLOBAL_RST = 32'h0140_000b;
  localparam logic [31:0] BETA_RST   = 32'h4010_4010;
  localparam logic [31:0] FILT_RST   = 32'h0020_0040;
  localparam logic [31:0] HALT_RST   = 32'h0080_0100;
  localparam logic [31:0] UI_RST     = 32'h0004_8100;
  localparam logic [31:0] TRIG_RST   = 32'h0000_2222;

  typedef enum logic [3:0] {
    ST_START = 4'b0001,
    ST_CONV  = 4'b0010,
    ST_TUNE  = 4'b0100,
    ST_TWAIT = 4'b1000
  } icp_state_t;

endpackage

// file: icp_chan_if.sv
// Interface joining the sequencer to the per-channel processing pipelines.
interface icp_chan_if;
  import icp_pkg::*;
  logic [CW-1:0] raw       [NCH];
  logic          sample_en [NCH];
  logic          reseed;
  logic [1:0]    avg_sel;
  logic [2:0]    band;
  logic [CW-1:0] target;
  logic [CW-1:0] rf_thr;
  logic [CW-1:0] halt_thr;
  logic [CW-1:0] fast_band;
  logic [CW-1:0] max_delta;
  logic [15:0]   halt_to;
  logic [7:0]    beta_norm;
  logic [7:0]    beta_fast;
  logic [3:0]    n_thr;
  logic [3:0]    hyst;
  logic [3:0]    trig      [NCH];
  logic [CW-1:0] filt      [NCH];
  logic [CW-1:0] lref      [NCH];
  logic [3:0]    level     [NCH];
  logic          active    [NCH];
  logic          halt_evt  [NCH];
  logic          ref_oob   [NCH];
  logic          cnt_oob   [NCH];

  modport ctrl (output raw, sample_en, reseed, avg_sel, band, target, rf_thr, halt_thr,
                fast_band, max_delta, halt_to, beta_norm, beta_fast, n_thr, hyst, trig,
                input filt, lref, level, active, halt_evt, ref_oob, cnt_oob);
  modport chan (input raw, sample_en, reseed, avg_sel, band, target, rf_thr, halt_thr,
                fast_band, max_delta, halt_to, beta_norm, beta_fast, n_thr, hyst, trig,
                output filt, lref, level, active, halt_evt, ref_oob, cnt_oob);
endinterface

// file: icp_channel.sv
// One channel: RF blanking, averaging, reference filter, halting and level output.
module icp_channel #(
  parameter int IDX = 0
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  icp_chan_if.chan  ch
);
  import icp_pkg::*;

  logic [CW-1:0]   hist_q [4];
  logic [CW-1:0]   prev_q;
  logic [3:0]      blank_q;
  logic [CW+7:0]   ref_q;
  logic [15:0]     hcnt_q;
  logic [3:0]      lvl_q;
  logic            act_q;
  logic            hevt_q;
  logic            upd_q;

  // ==========================================================================
  // Sampling and averaging
  wire logic [CW-1:0] raw     = ch.raw[IDX];
  wire logic          smp     = ch.sample_en[IDX];
  wire logic [CW-1:0] rdiff   = (raw > prev_q) ? raw - prev_q : prev_q - raw;
  wire logic          rf_hit  = smp && (rdiff > ch.rf_thr);
  wire logic          take    = smp && !rf_hit && (blank_q == 4'h0);
  wire logic [CW+1:0] s1      = {2'b00, hist_q[0]};
  wire logic [CW+1:0] s2      = s1 + {2'b00, hist_q[1]};
  wire logic [CW+1:0] s3      = s2 + {2'b00, hist_q[2]};
  wire logic [CW+1:0] s4      = s3 + {2'b00, hist_q[3]};
  wire logic [CW+1:0] d3      = s3 / 13'h3;
  wire logic [CW-1:0] filt    = (ch.avg_sel == 2'h0) ? s1[CW-1:0] :
                                (ch.avg_sel == 2'h1) ? s2[CW:1] :
                                (ch.avg_sel == AVG_DIV3) ? d3[CW-1:0] : s4[CW+1:2];

  // ==========================================================================
  // Delta, halting and reference filter
  wire logic [CW-1:0] lref    = ref_q[CW+7:FRAC];
  wire logic [CW-1:0] delta   = (filt > lref) ? filt - lref : lref - filt;
  wire logic          halt    = ((delta > ch.halt_thr) || act_q)
                                && (hcnt_q < ch.halt_to);
  wire logic [7:0]    beta    = (delta >= ch.fast_band) ? ch.beta_fast
                                                        : ch.beta_norm;
  wire logic signed [CW+9:0] err  = $signed({2'b00, filt, 8'h00}) - $signed({2'b00, ref_q});
  wire logic signed [CW+18:0] prod = err * $signed({1'b0, beta});
  wire logic signed [CW+18:0] incw = prod >>> FRAC;
  wire logic [CW+9:0] ref_nx  = CW'(0) + 21'($signed({2'b00, ref_q}) + incw[CW+9:0]);

  // ==========================================================================
  // Level quantisation with hysteresis
  wire logic [CW-1:0] step    = (ch.n_thr == 4'h0) ? '0 : ch.max_delta / ch.n_thr;
  wire logic [CW-1:0] qraw    = (step == '0) ? '0 : delta / step;
  wire logic [3:0]    qlvl    = (delta > ch.max_delta || qraw >= {7'h00, ch.n_thr}) ? ch.n_thr
                                : qraw[3:0];
  wire logic [CW+3:0] lbase   = {10'h000, lvl_q} * {3'b000, step};
  wire logic [CW+3:0] hext    = 14'(({4'h0, step} * {11'h000, ch.hyst}) >> 4);
  wire logic [CW+3:0] lfloor  = (hext > lbase) ? '0 : lbase - hext;
  wire logic          keep    = (qlvl < lvl_q) && ({4'h0, delta} >= lfloor);
  wire logic [3:0]    lvl_d   = keep ? lvl_q : qlvl;

  // ==========================================================================
  // Tuning band
  wire logic [CW-1:0] margin  = ch.target >> (ch.band + 3'h1);
  wire logic [CW:0]   hi_lim  = {1'b0, ch.target} + {1'b0, margin};
  wire logic [CW:0]   lo_lim  = {1'b0, ch.target} - {1'b0, margin};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
        hist_q[i] <= '0;
      prev_q  <= '0;
      blank_q <= 4'h0;
      upd_q   <= 1'b0;
    end
    else
    begin
      upd_q <= take;
      if (smp)
        prev_q <= raw;
      if (rf_hit)
        blank_q <= RF_BLANK;
      else if (smp && blank_q != 4'h0)
        blank_q <= blank_q - 4'h1;
      if (take)
      begin
        hist_q[0] <= raw;
        for (int i = 1; i < 4; i++)
          hist_q[i] <= hist_q[i-1];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_q  <= '0;
      hcnt_q <= 16'h0000;
      lvl_q  <= 4'h0;
      act_q  <= 1'b0;
      hevt_q <= 1'b0;
    end
    else
    begin
      hevt_q <= upd_q && halt;
      if (ch.reseed)
        ref_q <= {prev_q, 8'h00};
      else if (upd_q && !halt)
        ref_q <= ref_nx[CW+7:0];
      if (upd_q)
      begin
        hcnt_q <= halt ? hcnt_q + 16'h0001 :
                  ((delta > ch.halt_thr) ? hcnt_q : 16'h0000);
        lvl_q  <= lvl_d;
        act_q  <= lvl_d > ch.trig[IDX];
      end
    end
  end

  assign ch.filt[IDX]     = filt;
  assign ch.lref[IDX]     = lref;
  assign ch.level[IDX]    = lvl_q;
  assign ch.active[IDX]   = act_q;
  assign ch.halt_evt[IDX] = hevt_q;
  assign ch.ref_oob[IDX]  = ({1'b0, lref} > hi_lim) || ({1'b0, lref} < lo_lim);
  assign ch.cnt_oob[IDX]  = ({1'b0, prev_q} > hi_lim) || ({1'b0, prev_q} < lo_lim);

endmodule // icp_channel

// file: icp_core.sv
// Top of the inductive channel processing block with its register slave.
//
// Added by the designer: the address map and register access over Avalon-MM.

// Summary of operation
// - Raw counts above 2047 stop conversion and are reported as 2047.
// - Filtered count is the mean of the last one to four raw counts.
// - A raw jump above the RF threshold blanks samples for a few cycles.
// - Reference follows drift slowly and freezes while the channel is active.
// - Reseed bit loads every reference with its latest measured count.
// - Reference is a first-order IIR with damping beta divided by 256.
// - Reference updates stop while delta exceeds the filter-halt threshold.
// - A halted update sets that channel's filter-halt event bit.
// - A freeze lasts at most the programmed filter-halt timeout.
// - Normal and fast beta pairs exist per power mode; current mode selects.
// - Fast beta is used once delta reaches the fast-band threshold.
// - Delta is quantised into levels of max-delta over threshold count.
// - Delta above max-delta clamps the level to the threshold count.
// - Level above the trigger level raises activation event and flag.
// - Hysteresis lowers the current level's floor by a fraction of a step.
// - Retuning starts when a reference leaves target plus or minus band margin.
// - After tuning, any count outside the band sets the tuning-error bit.
// - A tuning error restarts tuning at once until it clears.
// - Two engines of two channels sample together over two scan cycles.
module icp_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             fe_start,
  output logic             fe_cycle,
  input  wire logic [11:0] fe_count_a,
  input  wire logic [11:0] fe_count_b,
  input  wire logic        fe_done,
  output logic             fe_stop,
  output logic             fe_tune,
  input  wire logic        fe_tune_done,
  output logic [3:0]       activation,
  output logic             tuning_error
);
  import icp_pkg::*;

  icp_chan_if ch ();

  icp_state_t  st_q;
  icp_state_t  st_d;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        lowpwr_q;
  logic        reseed_q;
  logic        tune_pend_q;
  logic [31:0] glb_q;
  logic [31:0] beta_q;
  logic [31:0] filt_q;
  logic [31:0] halt_q;
  logic [31:0] ui_q;
  logic [31:0] trig_q;
  logic [7:0]  events_q;
  logic        terr_q;
  logic        cycle_q;
  logic        pass_end_q;
  logic        post_tune_q;
  logic [3:0]  act_prev_q;

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the access completes.
  wire logic        req      = avs_read || avs_write;
  wire logic [3:0]  sel      = avs_address[5:2];
  wire logic        wr_en    = avs_write && ack_q;
  wire logic        wr_ctrl  = wr_en && (sel == IDX_CTRL);
  wire logic        wr_evt   = wr_en && (sel == IDX_EVENTS);
  wire logic [3:0]  cidx     = sel - IDX_COUNT0;
  wire logic        is_cnt   = (sel >= IDX_COUNT0) && (sel < IDX_COUNT0 + 4'h4);

  logic [3:0] act_v;
  logic [3:0] hevt_v;
  logic [3:0] roob_v;
  logic [3:0] coob_v;
  logic [15:0] lvl_v;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      act_v[i]        = ch.active[i];
      hevt_v[i]       = ch.halt_evt[i];
      roob_v[i]       = ch.ref_oob[i];
      coob_v[i]       = ch.cnt_oob[i];
      lvl_v[4*i +: 4] = ch.level[i];
    end
  end

  wire logic [31:0] cnt_rd  = {5'h00, ch.lref[cidx[1:0]], 5'h00, ch.filt[cidx[1:0]]};
  wire logic        tbusy   = (st_q == ST_TUNE) || (st_q == ST_TWAIT) || post_tune_q;
  wire logic [31:0] stat_rd = {24'h00_0000, act_v, 2'b00, tbusy, terr_q};
  wire logic [31:0] ctrl_rd = {30'h0000_0000, lowpwr_q, 1'b0};
  wire logic [31:0] rd_mux  =
      (sel == IDX_CTRL)   ? ctrl_rd :
      (sel == IDX_STAT)   ? stat_rd :
      (sel == IDX_EVENTS) ? {24'h00_0000, events_q} :
      (sel == IDX_GLOBAL) ? glb_q :
      (sel == IDX_BETA)   ? beta_q :
      (sel == IDX_FILT)   ? filt_q :
      (sel == IDX_HALT)   ? halt_q :
      (sel == IDX_UI)     ? ui_q :
      (sel == IDX_TRIG)   ? trig_q :
      (sel == IDX_LEVEL)  ? {16'h0000, lvl_v} :
      is_cnt              ? cnt_rd : 32'h0000_0000;

  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req && !ack_q;
      if (avs_read && !ack_q)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lowpwr_q <= 1'b0;
      glb_q    <= GLOBAL_RST;
      beta_q   <= BETA_RST;
      filt_q   <= FILT_RST;
      halt_q   <= HALT_RST;
      ui_q     <= UI_RST;
      trig_q   <= TRIG_RST;
    end
    else if (wr_en)
    begin
      case (sel)
        IDX_CTRL:   lowpwr_q <= avs_writedata[CTRL_LOWPWR];
        IDX_GLOBAL: glb_q    <= avs_writedata;
        IDX_BETA:   beta_q   <= avs_writedata;
        IDX_FILT:   filt_q   <= avs_writedata;
        IDX_HALT:   halt_q   <= avs_writedata;
        IDX_UI:     ui_q     <= avs_writedata;
        IDX_TRIG:   trig_q   <= avs_writedata;
        default:    lowpwr_q <= lowpwr_q;
      endcase
    end
  end

  // ==========================================================================
  // Events: sticky, write one to clear; a new event in the clearing cycle wins.
  wire logic [3:0] act_rise = act_v & ~act_prev_q;
  wire logic [7:0] evt_set  = {act_rise, hevt_v};
  wire logic [7:0] evt_clr  = wr_evt ? avs_writedata[7:0] : 8'h00;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      events_q   <= 8'h00;
      act_prev_q <= 4'h0;
    end
    else
    begin
      events_q   <= (events_q & ~evt_clr) | evt_set;
      act_prev_q <= act_v;
    end
  end

  // ==========================================================================
  // Configuration to the channels.
  assign ch.avg_sel   = glb_q[GLB_AVG +: 2];
  assign ch.band      = glb_q[GLB_BAND +: 3];
  assign ch.target    = glb_q[GLB_TARGET +: CW];
  assign ch.halt_thr  = filt_q[FLT_HALT +: CW];
  assign ch.fast_band = filt_q[FLT_FAST +: CW];
  assign ch.halt_to   = halt_q[HLT_TIMEOUT +: 16];
  assign ch.rf_thr    = halt_q[HLT_RF +: CW];
  assign ch.max_delta = ui_q[UI_MAXD +: CW];
  assign ch.n_thr     = ui_q[UI_NTHR +: 4];
  assign ch.hyst      = ui_q[UI_HYST +: 4];
  assign ch.beta_norm = lowpwr_q ? beta_q[23:16] : beta_q[7:0];
  assign ch.beta_fast = lowpwr_q ? beta_q[31:24] : beta_q[15:8];

  // ==========================================================================
  // Scan sequencer: engines A and B convert together, channels 0/1 then 2/3.
  wire logic        a_over = fe_count_a > SAT_LIMIT;
  wire logic        b_over = fe_count_b > SAT_LIMIT;
  wire logic [CW-1:0] sat_a = a_over ? SAT_LIMIT[CW-1:0] : fe_count_a[CW-1:0];
  wire logic [CW-1:0] sat_b = b_over ? SAT_LIMIT[CW-1:0] : fe_count_b[CW-1:0];
  wire logic        conv_done = (st_q == ST_CONV) && fe_done;
  wire logic        check     = (st_q == ST_START) && pass_end_q && post_tune_q;
  wire logic        err_now   = |coob_v;
  // References are stale until the post-tune reseed lands, so band drift is ignored here.
  wire logic        tune_go   = (st_q == ST_START) && pass_end_q &&
                                (tune_pend_q || (post_tune_q ? err_now : |roob_v));

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      ch.raw[i]       = i[0] ? sat_b : sat_a;
      ch.sample_en[i] = conv_done && (cycle_q == i[1]);
      ch.trig[i]      = trig_q[4*i +: 4];
    end
  end

  assign ch.reseed  = reseed_q;
  assign fe_start   = (st_q == ST_START) && !tune_go;
  assign fe_cycle   = cycle_q;
  assign fe_stop    = (st_q == ST_CONV) && (a_over || b_over);
  assign fe_tune    = (st_q == ST_TUNE);
  assign activation = act_v;
  assign tuning_error = terr_q;

  always_comb
  begin
    case (st_q)
      ST_START: st_d = tune_go ? ST_TUNE : ST_CONV;
      ST_CONV:  st_d = fe_done ? ST_START : ST_CONV;
      ST_TUNE:  st_d = ST_TWAIT;
      ST_TWAIT: st_d = fe_tune_done ? ST_START : ST_TWAIT;
      default:  st_d = ST_START;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q        <= ST_START;
      cycle_q     <= 1'b0;
      pass_end_q  <= 1'b0;
      post_tune_q <= 1'b0;
      tune_pend_q <= 1'b0;
      terr_q      <= 1'b0;
      reseed_q    <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      reseed_q <= (wr_ctrl && avs_writedata[CTRL_RESEED]) || (check && !err_now);
      if (wr_ctrl && avs_writedata[CTRL_TUNE])
        tune_pend_q <= 1'b1;
      else if (st_q == ST_TUNE)
        tune_pend_q <= 1'b0;
      if (conv_done)
      begin
        cycle_q    <= !cycle_q;
        pass_end_q <= cycle_q;
      end
      else if (st_q == ST_START)
        pass_end_q <= 1'b0;
      if (check)
      begin
        terr_q      <= err_now;
        post_tune_q <= 1'b0;
      end
      if (st_q == ST_TWAIT && fe_tune_done)
      begin
        post_tune_q <= 1'b1;
        cycle_q     <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_chan
      icp_channel #(.IDX(g)) u_chan (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ch      (ch.chan)
      );
    end
  endgenerate

endmodule // icp_core

// file: icp_core_asserts.sv
// Port-level assertions for the inductive channel processing top.
module icp_core_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        fe_start,
  input wire logic        fe_cycle,
  input wire logic [11:0] fe_count_a,
  input wire logic [11:0] fe_count_b,
  input wire logic        fe_done,
  input wire logic        fe_stop,
  input wire logic        fe_tune,
  input wire logic [3:0]  activation,
  input wire logic        tuning_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ====================
  // Front end sequencing
  a_stop_cause: assert property (
    fe_stop |-> (fe_count_a > 12'h7ff || fe_count_b > 12'h7ff))
    else $error("stop without over-limit count");
  a_done_next: assert property (
    fe_done |-> ##[1:3] (fe_start || fe_tune))
    else $error("no start after done");
  a_cycle_flip: assert property (
    fe_done |=> fe_cycle != $past(fe_cycle))
    else $error("scan cycle did not alternate");
  a_cycle_hold: assert property (
    !fe_done |=> $stable(fe_cycle))
    else $error("scan cycle moved mid conversion");
  // ====================
  // Tuning and outputs
  a_tune_pulse: assert property (
    fe_tune |=> !fe_tune)
    else $error("tune request longer than one cycle");
  a_err_retune: assert property (
    $rose(tuning_error) |-> ##[0:3] fe_tune)
    else $error("tuning error without retune");
  a_act_time: assert property (
    $changed(activation) |-> $past(fe_done, 2))
    else $error("activation moved outside update");
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
endmodule // icp_core_asserts

bind icp_core icp_core_asserts u_chk (.clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .fe_start, .fe_cycle, .fe_count_a, .fe_count_b, .fe_done, .fe_stop, .fe_tune, .activation,
  .tuning_error);

// file: icp_fe_model.sv
// Behavioural model of the two-engine inductive front end.
module icp_fe_model (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             fe_start,
  input  wire logic             fe_cycle,
  input  wire logic             fe_stop,
  input  wire logic             fe_tune,
  input  wire logic [3:0][11:0] val,
  input  wire logic             slow,
  output logic      [11:0]      fe_count_a,
  output logic      [11:0]      fe_count_b,
  output logic                  fe_done,
  output logic                  fe_tune_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  logic       conv_q;
  logic       tun_q;
  logic       cyc_q;
  // Counts are valid while converting and in the done cycle; at other times the value is the inverse.
  assign fe_count_a = (conv_q || fe_done) ? val[{cyc_q, 1'b0}] : ~val[{cyc_q, 1'b0}];
  assign fe_count_b = (conv_q || fe_done) ? val[{cyc_q, 1'b1}] : ~val[{cyc_q, 1'b1}];
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {cnt_q, conv_q, tun_q, cyc_q, fe_done, fe_tune_done} <= '0;
    end
    else
    begin
      fe_done <= 1'b0;
      fe_tune_done <= 1'b0;
      cnt_q <= cnt_q + 3'h1;
      if (fe_start && !conv_q && !tun_q)
      begin
        conv_q <= 1'b1;
        cyc_q <= fe_cycle;
        cnt_q <= '0;
      end
      else if (conv_q && (fe_stop || cnt_q == (slow ? 3'h6 : 3'h1)))
      begin
        conv_q <= 1'b0;
        fe_done <= 1'b1;
      end
      if (fe_tune)
      begin
        tun_q <= 1'b1;
        cnt_q <= '0;
      end
      else if (tun_q && cnt_q == 3'h3)
      begin
        tun_q <= 1'b0;
        fe_tune_done <= 1'b1;
      end
    end
  end
endmodule // icp_fe_model

// file: icp_core_tb_top.sv
// Self-checking testbench for the inductive channel processing block.
module icp_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import icp_pkg::*;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             slow = 1'b0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [5:0]       avs_address = '0;
  logic [31:0]      avs_writedata = '0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest, fe_start, fe_cycle, fe_done, fe_stop, fe_tune;
  logic             fe_tune_done, tuning_error;
  logic [11:0]      fe_count_a, fe_count_b;
  logic [3:0]       activation;
  logic [3:0][11:0] val = {12'h1f4, 12'h140, 12'h140, 12'h140};
  logic [5:0]       ra [7] = '{6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h3c};
  logic [31:0]      rv [7] = '{GLOBAL_RST, BETA_RST, FILT_RST, HALT_RST, UI_RST, TRIG_RST, '0};
  int               errors = 0;
  int               samples_checked = 0;

  icp_core dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .fe_start, .fe_cycle, .fe_count_a, .fe_count_b,
    .fe_done, .fe_stop, .fe_tune, .fe_tune_done, .activation, .tuning_error);
  icp_fe_model u_fe (.clk, .sys_rst, .fe_start, .fe_cycle, .fe_stop, .fe_tune, .val,
    .slow, .fe_count_a, .fe_count_b, .fe_done, .fe_tune_done);

  always #5 clk = ~clk;

  // ====================
  // Closing, compare and bus tasks
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      chk("bus wait bound", '0, 32'h0000_0001);
      conclude();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(nm, e, q & m);
  endtask
  // Waits for k conversions, or for the tuning error level v when k is zero.
  task automatic settle(input int k, input logic v);
    int n;
    int c;
    n = 0;
    c = 0;
    while (n < 4000 && (k > 0 ? c < k : tuning_error !== v))
    begin
      @(posedge clk);
      n++;
      c += int'(fe_done === 1'b1);
    end
    if (n >= 4000)
    begin
      chk("wait bound", '0, 32'h0000_0001);
      conclude();
    end
  endtask

  // ====================
  // Scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    wr(6'h3c, 32'hffff_ffff);
    foreach (ra[i])
      rc("register reset", ra[i], 32'hffff_ffff, rv[i]);
    settle(0, 1'b1);
    rc("status error", 6'h04, 32'h0000_0001, 32'h0000_0001);
    val[3] <= 12'h140;
    wr(6'h14, 32'h0020_0000);
    settle(0, 1'b0);
    settle(24, 1'b0);
    for (int i = 0; i < 4; i++)
      rc("count", 6'(40 + 4 * i), 32'h07ff_07ff, 32'h0140_0140);
    wr(6'h08, 32'h0000_00ff);
    val[0] <= 12'h900;
    val[1] <= 12'h1a4;
    val[2] <= 12'h180;
    slow <= 1'b1;
    settle(24, 1'b0);
    rc("count ch0", 6'h28, 32'h07ff_07ff, 32'h0140_07ff);
    rc("count ch1", 6'h2c, 32'h07ff_07ff, 32'h0140_01a4);
    rc("levels", 6'h24, 32'h0000_ffff, 32'h0000_0238);
    rc("events", 6'h08, 32'h0000_00ff, 32'h0000_0037);
    rc("status", 6'h04, 32'h0000_00f1, 32'h0000_0030);
    chk("activation", 32'h0000_0003, 32'(activation));
    val[1] <= 12'h19e;
    settle(12, 1'b0);
    rc("level ch1 held", 6'h24, 32'h0000_00f0, 32'h0000_0030);
    val[1] <= 12'h194;
    settle(12, 1'b0);
    rc("level ch1 drop", 6'h24, 32'h0000_00f0, 32'h0000_0020);
    chk("activation", 32'h0000_0001, 32'(activation));
    wr(6'h00, 32'h0000_0001);
    settle(4, 1'b0);
    rc("reseed ch1", 6'h2c, 32'h07ff_07ff, 32'h0194_0194);
    settle(0, 1'b1);
    conclude();
  end
endmodule // icp_core_tb_top
